//--- rtl/nva_pkg.sv
// constants and carrier types of the nonvolatile access block
package nva_pkg;

	// register offsets on the plain register port
	localparam logic [3:0] OFF_CTRL   = 4'h0;
	localparam logic [3:0] OFF_UNLOCK = 4'h1;
	localparam logic [3:0] OFF_DATA   = 4'h2;
	localparam logic [3:0] OFF_ADRL   = 4'h3;
	localparam logic [3:0] OFF_ADRH   = 4'h4;
	localparam logic [3:0] OFF_PTRL   = 4'h5;
	localparam logic [3:0] OFF_PTRH   = 4'h6;
	localparam logic [3:0] OFF_PTRU   = 4'h7;
	localparam logic [3:0] OFF_LATCH  = 4'h8;
	localparam logic [3:0] OFF_FLAG   = 4'h9;
	localparam logic [3:0] OFF_TBLCMD = 4'hA;

	// memory_access_control bit positions; BIT_DONE is in the flag register
	localparam int BIT_PDS  = 7;
	localparam int BIT_CFG  = 6;
	localparam int BIT_FREE = 4;
	localparam int BIT_ERR  = 3;
	localparam int BIT_WEN  = 2;
	localparam int BIT_WR   = 1;
	localparam int BIT_RD   = 0;
	localparam int BIT_DONE = 0;

	// unlock keys, values arbitrary
	localparam logic [7:0] KEY_FIRST  = 8'hA5;
	localparam logic [7:0] KEY_SECOND = 8'h3C;

	// table read pointer modes
	localparam logic [1:0] TBL_HOLD    = 2'h0;
	localparam logic [1:0] TBL_POSTINC = 2'h1;
	localparam logic [1:0] TBL_POSTDEC = 2'h2;
	localparam logic [1:0] TBL_PREINC  = 2'h3;

	// erased-cell and read fill values
	localparam logic [7:0] EE_ERASED = 8'hFF;
	localparam logic [7:0] RD_ZERO   = 8'h00;

	// write timer
	localparam int WRITE_TIME_NS = 4000000;
	localparam int CLK_NS        = 8;
	localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_NS;

	// one register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} nva_bus_type;

	typedef enum logic [1:0] {
		ST_IDLE     = 2'b00,
		ST_EE_WRITE = 2'b01,
		ST_PM_WRITE = 2'b10
	} nva_state_type;

endpackage

//--- rtl/nva_top.sv
// nonvolatile memory access control: select, table read, eeprom access
//
// What this block does
// (R01) unlock port holds nothing; it only arms the write sequence
// (R02) reading the unlock port returns all zeros
// (R03) program/data select low targets eeprom, high targets program memory
// (R04) config-space select set targets configuration space regardless
// (R05) config-space select clear: program/data select alone decides target
// (R06) erase-enable set makes next write-start a program memory erase
// (R07) writes allowed only with write-permit set; permit clear after reset
// (R08) write-error set when write-start set, cleared when timer expires
// (R09) write cut by reset or started improperly leaves write-error at one
// (R10) firmware may set write-start, only hardware clears it at completion
// (R11) completion sets memory-done flag, held until firmware clears it
// (R12) table read fetches one program byte at pointer into table latch
// (R13) table read may update the pointer for the next read
// (R14) pointer lowest bit picks high or low byte of the word
// (R15) eeprom byte reads and writes through data and address registers
// (R16) eeprom byte write erases then programs, timed on chip
// (R17) low address register spans eeprom locations 00h to FFh
// (R18) high address register adds two bits, 1024 bytes total
// (R19) read-start and write-start begin operations; hardware clears them
// (R20) read-start cannot be set while program memory is selected
// (R21) firmware sets permit and unlocks first; otherwise write-start ignored
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module nva_top #(
	parameter int WRITE_CYCLES = nva_pkg::WRITE_CYCLES
) (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// register port
	input  wire nva_pkg::nva_bus_type bus,
	output logic [7:0]               rd_data_q,
	// program memory port
	output logic [20:0]              pm_addr_q,
	output logic                     pm_cfg_q,
	output logic                     pm_rd_q,
	output logic                     pm_erase_q,
	input  wire logic [15:0]         pm_word
);

	// register write decode, shared by every write path
	function automatic logic wr_at(
		input nva_pkg::nva_bus_type b,
		input logic [3:0]           off
	);
		wr_at = b.wr && (b.addr == off);
	endfunction

	logic [7:0]  ee_mem [0:1023];
	logic        pds_q;
	logic        cfg_q;
	logic        free_q;
	logic        err_q;
	logic        wen_q;
	logic        wr_q;
	logic        rd_q;
	logic [7:0]  data_q;
	logic [7:0]  adrl_q;
	logic [1:0]  adrh_q;
	logic [21:0] ptr_q;
	logic [7:0]  latch_q;
	logic        done_q;
	logic        key1_q;
	logic        arm_q;
	logic        hi_q;
	logic [9:0]  wa_q;
	logic [7:0]  wd_q;
	logic [19:0] cnt_q;
	nva_pkg::nva_state_type st_q;

	logic        ctrl_wr;
	logic        wr_req;
	logic        wr_go;
	logic        wr_bad;
	logic        rd_go;
	logic        pm_tgt;
	logic        op_end;
	logic        tbl_go;
	logic [1:0]  tbl_mode;
	logic [21:0] tbl_eff;
	logic [9:0]  ee_addr;
	logic [7:0]  rd_mux;

	// control decode; select bits come from the same write as the start bit
	always_comb
	begin
		ctrl_wr  = wr_at(bus, nva_pkg::OFF_CTRL);
		wr_req   = ctrl_wr && bus.wdata[nva_pkg::BIT_WR];
		// a start needs permit and a fresh unlock; else it is refused
		wr_go    = wr_req && !wr_q && wen_q && arm_q; // R07 R21
		wr_bad   = wr_req && !wr_q && !(wen_q && arm_q); // R09
		pm_tgt   = bus.wdata[nva_pkg::BIT_CFG]
			|| bus.wdata[nva_pkg::BIT_PDS]; // R03 R04 R05
		rd_go    = ctrl_wr && bus.wdata[nva_pkg::BIT_RD] && !pm_tgt
			&& (st_q == nva_pkg::ST_IDLE); // R20
		op_end   = (st_q != nva_pkg::ST_IDLE)
			&& (cnt_q == 20'(WRITE_CYCLES - 1));
		tbl_go   = wr_at(bus, nva_pkg::OFF_TBLCMD);
		tbl_mode = bus.wdata[1:0];
		tbl_eff  = (tbl_mode == nva_pkg::TBL_PREINC)
			? ptr_q + 22'h1 : ptr_q;
		ee_addr  = {adrh_q, adrl_q}; // R17 R18
	end

	// select, erase-enable and permit bits; permit comes up clear
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pds_q  <= 1'b0;
			cfg_q  <= 1'b0;
			free_q <= 1'b0;
			wen_q  <= 1'b0; // R07
		end
		else if (ctrl_wr)
		begin
			pds_q  <= bus.wdata[nva_pkg::BIT_PDS]; // R03
			cfg_q  <= bus.wdata[nva_pkg::BIT_CFG]; // R04
			free_q <= bus.wdata[nva_pkg::BIT_FREE]; // R06
			wen_q  <= bus.wdata[nva_pkg::BIT_WEN];
		end
	end

	// unlock port: two keys in a row arm one start, nothing is kept
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			key1_q <= 1'b0;
			arm_q  <= 1'b0;
		end
		else if (bus.wr)
		begin
			// any other write breaks the sequence
			key1_q <= wr_at(bus, nva_pkg::OFF_UNLOCK)
				&& (bus.wdata == nva_pkg::KEY_FIRST); // R01
			arm_q  <= wr_at(bus, nva_pkg::OFF_UNLOCK) && key1_q
				&& (bus.wdata == nva_pkg::KEY_SECOND); // R01
		end
	end

	// write-start: set only by firmware, cleared at completion or by reset
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			wr_q <= 1'b0;
		else if (wr_go)
			wr_q <= 1'b1; // R10 R19
		else if (op_end)
			wr_q <= 1'b0; // R10
	end

	// write-error; once set it outlives a reset of any length, so a cut
	// write stays visible; only a later completion clears it
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			if (wr_q || err_q)
				err_q <= 1'b1; // R09
			else
				err_q <= 1'b0;
		end
		else if (wr_go || wr_bad)
			err_q <= 1'b1; // R08 R09
		else if (op_end)
			err_q <= 1'b0; // R08
	end

	// read-start lasts one cycle, the array answers at once
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			rd_q <= 1'b0;
		else
			rd_q <= rd_go; // R19
	end

	// write sequencer and on-chip timer
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st_q  <= nva_pkg::ST_IDLE;
			cnt_q <= 20'h00000;
		end
		else
		begin
			case (st_q)
				nva_pkg::ST_IDLE:
				begin
					cnt_q <= 20'h00000;
					if (wr_go && pm_tgt)
						st_q <= nva_pkg::ST_PM_WRITE; // R03 R04
					else if (wr_go)
						st_q <= nva_pkg::ST_EE_WRITE; // R05
				end
				nva_pkg::ST_EE_WRITE, nva_pkg::ST_PM_WRITE:
				begin
					if (op_end)
						st_q <= nva_pkg::ST_IDLE; // R16
					else
						cnt_q <= cnt_q + 20'h00001;
				end
				default:
					st_q <= nva_pkg::ST_IDLE;
			endcase
		end
	end

	// program memory erase is a one-cycle pulse at the start
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			pm_erase_q <= 1'b0;
		else
			pm_erase_q <= wr_go && pm_tgt
				&& bus.wdata[nva_pkg::BIT_FREE]; // R06
	end

	// target captured at start so later register writes cannot move it
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			wa_q <= 10'h000;
			wd_q <= 8'h00;
		end
		else if (wr_go)
		begin
			wa_q <= ee_addr;
			wd_q <= data_q; // R15
		end
	end

	// eeprom array: erase at start, program at timer expiry
	always_ff @(posedge clk_sys)
	begin
		if (wr_go && !pm_tgt)
			ee_mem[ee_addr] <= nva_pkg::EE_ERASED; // R16
		else if (op_end && (st_q == nva_pkg::ST_EE_WRITE))
			ee_mem[wa_q] <= wd_q; // R16
	end

	// eeprom data register: firmware write or array read
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			data_q <= 8'h00;
		else if (rd_go)
			data_q <= ee_mem[ee_addr]; // R15
		else if (wr_at(bus, nva_pkg::OFF_DATA))
			data_q <= bus.wdata; // R15
	end

	// eeprom address registers
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			adrl_q <= 8'h00;
			adrh_q <= 2'h0;
		end
		else
		begin
			if (wr_at(bus, nva_pkg::OFF_ADRL))
				adrl_q <= bus.wdata; // R17
			if (wr_at(bus, nva_pkg::OFF_ADRH))
				adrh_q <= bus.wdata[1:0]; // R18
		end
	end

	// completion flag; a new completion beats a clear
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			done_q <= 1'b0;
		else if (op_end)
			done_q <= 1'b1; // R11
		else if (wr_at(bus, nva_pkg::OFF_FLAG)
			&& !bus.wdata[nva_pkg::BIT_DONE])
			done_q <= 1'b0; // R11
	end

	// table pointer: byte writes, or stepping by a table read
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			ptr_q <= 22'h000000;
		else if (tbl_go)
		begin
			case (tbl_mode)
				nva_pkg::TBL_POSTINC:
					ptr_q <= ptr_q + 22'h1; // R13
				nva_pkg::TBL_POSTDEC:
					ptr_q <= ptr_q - 22'h1; // R13
				nva_pkg::TBL_PREINC:
					ptr_q <= tbl_eff; // R13
				default:
					ptr_q <= ptr_q;
			endcase
		end
		else
		begin
			if (wr_at(bus, nva_pkg::OFF_PTRL))
				ptr_q[7:0] <= bus.wdata;
			if (wr_at(bus, nva_pkg::OFF_PTRH))
				ptr_q[15:8] <= bus.wdata;
			if (wr_at(bus, nva_pkg::OFF_PTRU))
				ptr_q[21:16] <= bus.wdata[5:0];
		end
	end

	// table read request: word address out, byte half kept aside
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pm_rd_q   <= 1'b0;
			pm_addr_q <= 21'h000000;
			pm_cfg_q  <= 1'b0;
			hi_q      <= 1'b0;
		end
		else
		begin
			pm_rd_q <= tbl_go; // R12
			if (tbl_go)
			begin
				pm_addr_q <= tbl_eff[21:1]; // R14
				pm_cfg_q  <= cfg_q; // R04
				hi_q      <= tbl_eff[0]; // R14
			end
		end
	end

	// the word must be valid while the request stands
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			latch_q <= 8'h00;
		else if (pm_rd_q)
			latch_q <= hi_q ? pm_word[15:8] : pm_word[7:0]; // R12 R14
	end

	// read mux; the unlock port and unmapped offsets give zero
	always_comb
	begin
		case (bus.addr)
			nva_pkg::OFF_CTRL:
				rd_mux = {pds_q, cfg_q, 1'b0, free_q,
					err_q, wen_q, wr_q, rd_q};
			nva_pkg::OFF_DATA:   rd_mux = data_q;
			nva_pkg::OFF_ADRL:   rd_mux = adrl_q;
			nva_pkg::OFF_ADRH:   rd_mux = {6'h00, adrh_q};
			nva_pkg::OFF_PTRL:   rd_mux = ptr_q[7:0];
			nva_pkg::OFF_PTRH:   rd_mux = ptr_q[15:8];
			nva_pkg::OFF_PTRU:   rd_mux = {2'h0, ptr_q[21:16]};
			nva_pkg::OFF_LATCH:  rd_mux = latch_q;
			nva_pkg::OFF_FLAG:   rd_mux = {7'h00, done_q};
			default:             rd_mux = nva_pkg::RD_ZERO; // R02
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			rd_data_q <= 8'h00;
		else if (bus.rd)
			rd_data_q <= rd_mux;
		else
			rd_data_q <= 8'h00;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	chk_unlock_reads_zero: assert property ( // R02
		bus.rd && (bus.addr == nva_pkg::OFF_UNLOCK) |=> rd_data_q == 8'h00)
		else $error("unlock port read not zero");

	chk_eeprom_target: assert property ( // R03
		wr_go && !pm_tgt |=> st_q == nva_pkg::ST_EE_WRITE)
		else $error("eeprom write not started");

	chk_config_target: assert property ( // R04
		wr_go && bus.wdata[nva_pkg::BIT_CFG]
		|=> st_q == nva_pkg::ST_PM_WRITE)
		else $error("config select ignored");

	chk_erase_pulse: assert property ( // R06
		$rose(pm_erase_q) |-> $past(wr_go) && $past(bus.wdata[4]))
		else $error("erase without enable");

	chk_permit_gate: assert property ( // R07
		$rose(wr_q) |-> $past(wen_q) && $past(arm_q))
		else $error("write started without permit");

	chk_error_follows_start: assert property ( // R08
		wr_q |-> err_q)
		else $error("write-error not set during write");

	chk_bad_start_error: assert property ( // R09
		wr_bad |=> err_q && !wr_q)
		else $error("improper start not flagged");

	chk_start_held: assert property ( // R10
		wr_q && !op_end |=> wr_q)
		else $error("write-start dropped early");

	chk_done_flag_set: assert property ( // R11
		op_end |=> done_q && !wr_q)
		else $error("completion flag missing");

	chk_table_byte: assert property ( // R12
		pm_rd_q |=> latch_q == ($past(hi_q) ? $past(pm_word[15:8])
			: $past(pm_word[7:0])))
		else $error("table latch wrong byte");

	chk_pointer_step: assert property ( // R13
		tbl_go && (tbl_mode == nva_pkg::TBL_POSTINC)
		|=> ptr_q == 22'($past(ptr_q) + 22'h1))
		else $error("pointer not advanced");

	chk_read_start_clear: assert property ( // R19
		rd_q |=> !rd_q)
		else $error("read-start not cleared");

	chk_program_no_read: assert property ( // R20
		ctrl_wr && pm_tgt |=> !rd_q)
		else $error("read-start set on program memory");

endmodule

`default_nettype wire

//--- dv/nva_pm_model.sv
// program memory stand-in that answers table-read fetches
`timescale 1ns/1ps
`default_nettype none

module nva_pm_model (
	// clock
	input  wire logic        clk_sys,
	// fetch request from the block
	input  wire logic [20:0] pm_addr_q,
	input  wire logic        pm_cfg_q,
	input  wire logic        pm_rd_q,
	// word back to the block
	output logic [15:0]      pm_word
);
	logic [15:0] junk_q = 16'hA5A5;

	// word is valid only while the fetch strobe stands; a moving pattern
	// otherwise, so a late sample cannot pass by luck
	always_comb
	begin
		if (pm_rd_q)
			pm_word = {pm_addr_q[7:0] ^ 8'hC3, pm_addr_q[7:0]}
				^ {16{pm_cfg_q}};
		else
			pm_word = junk_q;
	end

	// idle pattern changes every cycle
	always_ff @(posedge clk_sys)
		junk_q <= ~junk_q + 16'h1357;
endmodule
`default_nettype wire

//--- dv/tb_nva_top.sv
// self-checking bench of the nonvolatile access block
`timescale 1ns/1ps
`default_nettype none

module tb_nva_top;
	localparam int WC = 20;
	logic                 clk_sys;
	logic                 rst;
	nva_pkg::nva_bus_type bus;
	logic [7:0]           rd_data_q;
	logic [20:0]          pm_addr_q;
	logic                 pm_cfg_q;
	logic                 pm_rd_q;
	logic                 pm_erase_q;
	logic [15:0]          pm_word;
	logic [20:0]          seen_addr;
	logic                 seen_cfg;
	logic [7:0]           got;
	int                   n_erase = 0;
	int                   n_mismatch = 0;
	int                   n_compared = 0;

	// short write time keeps the run brief
	nva_top #(.WRITE_CYCLES(WC)) nva_top_inst (
		.clk_sys(clk_sys), .rst(rst), .bus(bus), .rd_data_q(rd_data_q),
		.pm_addr_q(pm_addr_q), .pm_cfg_q(pm_cfg_q), .pm_rd_q(pm_rd_q),
		.pm_erase_q(pm_erase_q), .pm_word(pm_word));

	nva_pm_model nva_pm_model_inst (
		.clk_sys(clk_sys), .pm_addr_q(pm_addr_q), .pm_cfg_q(pm_cfg_q),
		.pm_rd_q(pm_rd_q), .pm_word(pm_word));

	// clock
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// remember each fetch request and count erase pulses
	always @(posedge clk_sys)
	begin
		if (pm_rd_q === 1'b1)
		begin
			seen_addr <= pm_addr_q;
			seen_cfg  <= pm_cfg_q;
		end
		if (pm_erase_q === 1'b1)
			n_erase <= n_erase + 1;
	end

	task automatic chk(input string what, input logic [23:0] exp,
		input logic [23:0] seen);
	begin
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask

	// every bus task is entered just after a rising edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
	begin
		bus <= {a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus <= '0;
		@(posedge clk_sys);
	end
	endtask

	// plain read; the data stand only in the cycle after the strobe
	task automatic rd_only(input logic [3:0] a);
	begin
		bus <= {a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		bus <= '0;
		#1;
		got = rd_data_q;
		@(posedge clk_sys);
	end
	endtask

	task automatic rc(input logic [3:0] a, input logic [7:0] e,
		input string what);
	begin
		rd_only(a);
		chk(what, {16'h0, e}, {16'h0, got});
	end
	endtask

	// permit first, then the two keys, then the start
	task automatic start(input logic [7:0] v);
	begin
		wr(nva_pkg::OFF_CTRL, v & 8'hFD);
		wr(nva_pkg::OFF_UNLOCK, nva_pkg::KEY_FIRST);
		wr(nva_pkg::OFF_UNLOCK, nva_pkg::KEY_SECOND);
		wr(nva_pkg::OFF_CTRL, v);
	end
	endtask

	// poll until write-start drops; too early or too late both fail
	task automatic wait_done(input logic [7:0] e);
		int i;
	begin
		for (i = 0; i < 40; i++)
		begin
			rd_only(nva_pkg::OFF_CTRL);
			if (got[nva_pkg::BIT_WR] === 1'b0)
				break;
			chk("ctrl busy", {16'h0, e | 8'h0A}, {16'h0, got});
		end
		chk("write time", 1'b1, i >= WC / 2 - 4 && i <= WC / 2);
		chk("ctrl at end", e, got);
		rc(nva_pkg::OFF_FLAG, 8'h01, "done flag");
		rc(nva_pkg::OFF_FLAG, 8'h01, "done flag held");
		wr(nva_pkg::OFF_FLAG, 8'h00);
		rc(nva_pkg::OFF_FLAG, 8'h00, "done flag cleared");
	end
	endtask

	task automatic ee(input logic [9:0] a, input logic [7:0] d,
		input logic put);
	begin
		wr(nva_pkg::OFF_ADRH, {6'h0, a[9:8]});
		wr(nva_pkg::OFF_ADRL, a[7:0]);
		if (put)
		begin
			wr(nva_pkg::OFF_DATA, d);
			start(8'h06);
			rc(nva_pkg::OFF_CTRL, 8'h0E, "ctrl busy");
			wr(nva_pkg::OFF_CTRL, 8'h04);
			rc(nva_pkg::OFF_CTRL, 8'h0E, "start kept");
			wait_done(8'h04);
		end
		else
		begin
			wr(nva_pkg::OFF_CTRL, 8'h01);
			rc(nva_pkg::OFF_DATA, d, "eeprom byte");
			rc(nva_pkg::OFF_CTRL, 8'h00, "read-start cleared");
		end
	end
	endtask

	task automatic t_basic();
	begin
		rc(nva_pkg::OFF_CTRL, 8'h00, "ctrl after reset");
		wr(nva_pkg::OFF_UNLOCK, 8'hFF);
		rc(nva_pkg::OFF_UNLOCK, 8'h00, "unlock port");
		rc(4'hB, 8'h00, "unmapped");
		wr(nva_pkg::OFF_CTRL, 8'h04);
		wr(nva_pkg::OFF_CTRL, 8'h06);
		rc(nva_pkg::OFF_CTRL, 8'h0C, "start refused");
		rc(nva_pkg::OFF_FLAG, 8'h00, "no completion");
		$display("test basic done");
	end
	endtask

	task automatic t_eeprom();
	begin
		ee(10'h2FF, 8'h5A, 1'b1);
		ee(10'h0FF, 8'hA3, 1'b1);
		ee(10'h2FF, 8'h5A, 1'b0);
		ee(10'h0FF, 8'hA3, 1'b0);
		chk("no erase pulse", 24'd0, n_erase);
		wr(nva_pkg::OFF_DATA, 8'h77);
		wr(nva_pkg::OFF_CTRL, 8'h81);
		rc(nva_pkg::OFF_CTRL, 8'h80, "read-start blocked");
		wr(nva_pkg::OFF_CTRL, 8'h41);
		rc(nva_pkg::OFF_CTRL, 8'h40, "cfg read blocked");
		rc(nva_pkg::OFF_DATA, 8'h77, "data untouched");
		start(8'h96);
		rc(nva_pkg::OFF_CTRL, 8'h9E, "erase busy");
		chk("erase pulse", 24'd1, n_erase);
		wait_done(8'h94);
		$display("test eeprom done");
	end
	endtask

	task automatic t_table();
		logic [1:0]  m [4];
		logic [7:0]  c [3];
		logic [21:0] p;
	begin
		m = '{nva_pkg::TBL_POSTINC, nva_pkg::TBL_PREINC,
			nva_pkg::TBL_POSTDEC, nva_pkg::TBL_HOLD};
		c = '{8'h40, 8'hC0, 8'h80};
		p = 22'h0001FF;
		wr(nva_pkg::OFF_PTRL, 8'hFF);
		wr(nva_pkg::OFF_PTRH, 8'h01);
		wr(nva_pkg::OFF_PTRU, 8'h00);
		wr(nva_pkg::OFF_CTRL, 8'h80);
		foreach (m[i])
		begin
			if (m[i] == nva_pkg::TBL_PREINC)
				p = p + 22'h1;
			wr(nva_pkg::OFF_TBLCMD, {6'h0, m[i]});
			rc(nva_pkg::OFF_LATCH, p[0] ? p[8:1] ^ 8'hC3 : p[8:1],
				"table latch");
			chk("fetch address", {3'h0, p[21:1]}, {3'h0, seen_addr});
			if (m[i] == nva_pkg::TBL_POSTINC)
				p = p + 22'h1;
			if (m[i] == nva_pkg::TBL_POSTDEC)
				p = p - 22'h1;
		end
		rc(nva_pkg::OFF_PTRL, p[7:0], "pointer low");
		rc(nva_pkg::OFF_PTRH, p[15:8], "pointer high");
		foreach (c[i])
		begin
			wr(nva_pkg::OFF_CTRL, c[i]);
			wr(nva_pkg::OFF_TBLCMD, {6'h0, nva_pkg::TBL_HOLD});
			rc(nva_pkg::OFF_LATCH, p[8:1] ^ {8{c[i][6]}},
				"space latch");
			chk("config space", c[i][6], seen_cfg);
		end
		$display("test table done");
	end
	endtask

	// reset in mid-write must leave the error bit standing
	task automatic t_cut();
	begin
		wr(nva_pkg::OFF_DATA, 8'h3D);
		start(8'h06);
		repeat (3) @(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rc(nva_pkg::OFF_CTRL, 8'h08, "error after cut");
		rc(nva_pkg::OFF_FLAG, 8'h00, "no flag after cut");
		$display("test cut done");
	end
	endtask

	task automatic report_and_stop();
	begin
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask

	// watchdog far beyond the few hundred cycles the tests need
	initial
	begin
		#100000;
		n_mismatch++;
		report_and_stop();
	end

	// main sequence
	initial
	begin
		bus = '0;
		rst = 1'b1;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		t_basic();
		t_eeprom();
		t_table();
		t_cut();
		report_and_stop();
	end
endmodule
`default_nettype wire
